// ===== ipr_pkg.sv
// Purpose: shared constants and types for the priority and routing store
// Assumes: one distributor clock, synchronous active-low reset
// Notes: geometry is fixed; each unit of interrupt_lines_count adds 32 interrupts (1 gives 64)
package ipr_pkg;
	localparam int          LINES_COUNT    = 1;                         // interrupt_lines_count
	localparam int          NUM_INT        = 32 * (LINES_COUNT + 1);
	localparam int          NUM_PRIO_WORDS = 8 * (LINES_COUNT + 1);
	localparam int          BANKED_WORDS   = 8;
	localparam int          NUM_BANKS      = 8;
	localparam int          FIRST_SPI      = 32;
	localparam int          NUM_SPI        = NUM_INT - FIRST_SPI;
	localparam int          NUM_LANES      = 4;
	localparam logic [15:0] PRIO_BASE      = 16'h0400;
	localparam logic [15:0] PRIO_END       = 16'h0440;                  // base + 4 * word count
	localparam logic [15:0] ROUTE_BASE     = 16'h6000;
	localparam logic [15:0] ROUTE_SPI_BASE = 16'h6100;                  // base + 8 * 32
	localparam logic [15:0] ROUTE_END      = 16'h6200;                  // base + 8 * NUM_INT
	localparam logic [1:0]  SIZE_BYTE      = 2'h0;
	localparam logic [1:0]  SIZE_WORD      = 2'h2;
	localparam logic [1:0]  SIZE_DWORD     = 2'h3;
	localparam logic [7:0]  PRIO_IMPL_MASK = 8'hF8;                     // five priority bits kept
	localparam logic [7:0]  PRIO_RESET     = 8'h00;
	localparam logic [7:0]  PRIO_IDLE      = 8'hFF;
	localparam logic [31:0] AFF_IMPL_MASK  = 32'h0000_030F;             // {lvl3,lvl2,lvl1,lvl0}
	localparam logic [31:0] AFF_RESET      = 32'h0000_0000;
	localparam logic [7:0]  NUM_PE         = 8'h08;                     // elements 0.0.0.0-0.0.0.7
	localparam logic        IRM_SUPPORTED  = 1'b1;
	localparam int          ROUTE_IRM_BIT  = 31;
	localparam logic [63:0] INT_IMPL_MASK  = 64'h7FFF_FFFF_FFFF_FFFF;   // interrupt 63 absent
	localparam logic [63:0] ROUTE_RSVD     = 64'hFFFF_FF00_7F00_0000;

	typedef enum logic [1:0] {FWD_IDLE, FWD_OFFER, FWD_SETTLE} ipr_fwd_state_t;
endpackage

// ===== ipr_prio_route.sv
// Purpose: priority words and shared-interrupt routing words with forwarding of the winner
// Assumes: one request per cycle on the register port; answer one cycle later
// Notes: byte reads return the field in bits 7:0; word reads of routing words pick a half
module ipr_prio_route import ipr_pkg::*; (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_req,
	input  wire logic        i_wr,
	input  wire logic        i_nonsecure,
	input  wire logic [1:0]  i_size,
	input  wire logic [15:0] i_addr,
	input  wire logic [63:0] i_wdata,
	input  wire logic [7:0]  i_pe_num,
	output logic             o_ack,
	output logic      [63:0] o_rdata,
	input  wire logic        i_security_disable,
	input  wire logic        i_are_secure,
	input  wire logic        i_are_nonsecure,
	input  wire logic [63:0] i_int_ns_group,
	input  wire logic [63:0] i_nsacr_grant,
	input  wire logic [31:0] i_spi_pending,
	input  wire logic        i_fwd_ack,
	output logic             o_fwd_valid,
	output logic      [9:0]  o_fwd_interrupt_number,
	output logic      [7:0]  o_fwd_prio,
	output logic      [31:0] o_fwd_affinity,
	output logic             o_fwd_any_pe,
	output logic             o_fwd_legacy
);
	logic [31:0]        prio_shared_r [BANKED_WORDS];
	logic [31:0]        prio_bank_r   [NUM_BANKS][BANKED_WORDS];
	logic [31:0]        route_aff_r   [NUM_SPI];
	logic [NUM_SPI-1:0] route_irm_r;
	logic               ack_r;
	logic [63:0]        rdata_r;
	ipr_fwd_state_t     state_r;
	logic               fwd_valid_r;
	logic [9:0]         fwd_interrupt_number_r;
	logic [7:0]         fwd_prio_r;
	logic [31:0]        fwd_aff_r;
	logic               fwd_any_r;
	logic               fwd_legacy_r;

	logic [15:0] prio_off;
	logic [15:0] route_off;
	logic        prio_hit;
	logic        route_hit;
	logic        banked;
	logic [3:0]  prio_word;
	logic [3:0]  lane_sel;
	logic [3:0]  lane_ok;
	logic [31:0] byte_mask;
	logic [31:0] cur_word;
	logic [31:0] rd_word;
	logic [31:0] new_word;
	logic [4:0]  spi_idx;
	logic        route_ok_now;
	logic [63:0] route_cur;
	logic [63:0] route_merged;
	logic [63:0] rd_data;

	ipr_sel_if sel_bus ();

	ipr_prio_select u_select (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.sel        (sel_bus.pick)
	);

	// affinity routing state of the interrupt's own security state
	function automatic logic are_for(input logic [5:0] m);
		if (i_security_disable || i_int_ns_group[m])
			return i_are_nonsecure;
		return i_are_secure;
	endfunction

	// may this access touch priority field m
	function automatic logic prio_ok(input logic [5:0] m);
		logic ok;
		ok = INT_IMPL_MASK[m];
		if (m[5:2] < 4'(BANKED_WORDS))
			ok = ok && !are_for(m) && i_pe_num < 8'(NUM_BANKS);
		if (i_nonsecure && !i_security_disable && !i_int_ns_group[m])
			ok = 1'b0;
		return ok;
	endfunction

	// may this access touch routing word m
	function automatic logic route_ok(input logic [5:0] m);
		logic ok;
		ok = INT_IMPL_MASK[m] && are_for(m);
		if (i_nonsecure && !i_security_disable && !i_int_ns_group[m] && !i_nsacr_grant[m])
			ok = 1'b0;
		return ok;
	endfunction

	// affinity packed as {lvl3,lvl2,lvl1,lvl0}; placed into the 64-bit layout
	function automatic logic [63:0] route_pack(input logic [31:0] aff, input logic routing_mode_bit);
		return {24'h00_0000, aff[31:24], routing_mode_bit, 7'h00, aff[23:0]};
	endfunction

	function automatic logic tgt_impl(input logic [31:0] aff);
		return aff[31:8] == 24'h00_0000 && aff[7:0] < NUM_PE;
	endfunction

	// address decode for both register arrays
	always_comb begin
		prio_off  = i_addr - PRIO_BASE;
		route_off = i_addr - ROUTE_BASE;
		prio_word = prio_off[5:2];
		prio_hit  = i_addr >= PRIO_BASE && i_addr < PRIO_END &&
			(i_size == SIZE_BYTE || (i_size == SIZE_WORD && i_addr[1:0] == 2'h0));
		lane_sel  = (i_size == SIZE_BYTE) ? 4'(4'h1 << i_addr[1:0]) : 4'hF;
		banked    = prio_word < 4'(BANKED_WORDS);
		spi_idx   = route_off[7:3];
		route_hit = i_addr >= ROUTE_SPI_BASE && i_addr < ROUTE_END &&
			((i_size == SIZE_DWORD && i_addr[2:0] == 3'h0) ||
			 (i_size == SIZE_WORD && i_addr[1:0] == 2'h0));
	end

	// per-lane view of the addressed priority word
	always_comb begin
		cur_word = banked ? prio_bank_r[i_pe_num[2:0]][prio_word[2:0]]
		                  : prio_shared_r[prio_word[2:0]];
		rd_word  = '0;
		new_word = cur_word;
		for (int l = 0; l < NUM_LANES; l++) begin
			lane_ok[l]         = lane_sel[l] && prio_ok({prio_word, 2'(l)});
			byte_mask[l*8 +: 8] = {8{lane_sel[l]}};
			if (lane_ok[l]) begin
				rd_word[l*8 +: 8]  = cur_word[l*8 +: 8];
				new_word[l*8 +: 8] = ((i_size == SIZE_BYTE) ? i_wdata[7:0] : i_wdata[l*8 +: 8])
					& PRIO_IMPL_MASK;
			end
		end
	end

	// routing word view; a half-word write merges with the other half
	always_comb begin
		route_ok_now = route_ok({1'b1, spi_idx});
		route_cur    = route_pack(route_aff_r[spi_idx], route_irm_r[spi_idx]);
		if (i_size == SIZE_DWORD)
			route_merged = i_wdata;
		else if (i_addr[2])
			route_merged = {i_wdata[31:0], route_cur[31:0]};
		else
			route_merged = {route_cur[63:32], i_wdata[31:0]};
		rd_data = '0;
		if (prio_hit) begin
			rd_data[31:0] = (i_size == SIZE_BYTE) ? 32'(rd_word >> {i_addr[1:0], 3'h0}) : rd_word;
		end else if (route_hit && route_ok_now) begin
			if (i_size == SIZE_DWORD)
				rd_data = route_cur;
			else
				rd_data[31:0] = i_addr[2] ? route_cur[63:32] : route_cur[31:0];
		end
	end

	// shared priority words; a byte write changes only its lane
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			for (int w = 0; w < BANKED_WORDS; w++)
				prio_shared_r[w] <= {NUM_LANES{PRIO_RESET}};
		end else if (i_req && i_wr && prio_hit && !banked) begin
			prio_shared_r[prio_word[2:0]] <= new_word;
		end
	end

	// per-element copies of words 0-7; elements 8 and up are shut out by prio_ok
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			for (int b = 0; b < NUM_BANKS; b++)
				for (int w = 0; w < BANKED_WORDS; w++)
					prio_bank_r[b][w] <= {NUM_LANES{PRIO_RESET}};
		end else if (i_req && i_wr && prio_hit && banked && lane_ok != 4'h0) begin
			prio_bank_r[i_pe_num[2:0]][prio_word[2:0]] <= new_word;
		end
	end

	// routing words; fields keep their old value across affinity enable, a legal unknown
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			for (int k = 0; k < NUM_SPI; k++)
				route_aff_r[k] <= AFF_RESET;
			route_irm_r <= '0;
		end else if (i_req && i_wr && route_hit && route_ok_now) begin
			if (!route_irm_r[spi_idx])
				route_aff_r[spi_idx] <= {route_merged[39:32], route_merged[23:0]} & AFF_IMPL_MASK;
			route_irm_r[spi_idx] <= route_merged[ROUTE_IRM_BIT] & IRM_SUPPORTED;
		end
	end

	// register answer; writes answer with zero data
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			ack_r   <= 1'b0;
			rdata_r <= '0;
		end else begin
			ack_r   <= i_req;
			rdata_r <= (i_req && !i_wr) ? rd_data : 64'h0000_0000_0000_0000;
		end
	end

	// candidates: pending, implemented and routable to somewhere
	always_comb begin
		for (int k = 0; k < NUM_SPI; k++) begin
			sel_bus.prio[k] = prio_shared_r[k / NUM_LANES][(k % NUM_LANES) * 8 +: 8];
			sel_bus.cand[k] = i_spi_pending[k] && INT_IMPL_MASK[FIRST_SPI + k] &&
				(!are_for(6'(FIRST_SPI + k)) || route_irm_r[k] || tgt_impl(route_aff_r[k]));
		end
	end

	// offer holds a snapshot of the settings, so a change mid-offer never splits the event
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			state_r      <= FWD_IDLE;
			fwd_valid_r  <= 1'b0;
			fwd_interrupt_number_r  <= '0;
			fwd_prio_r   <= '0;
			fwd_aff_r    <= '0;
			fwd_any_r    <= 1'b0;
			fwd_legacy_r <= 1'b0;
		end else begin
			case (state_r)
				FWD_IDLE: begin
					if (sel_bus.found) begin
						state_r      <= FWD_OFFER;
						fwd_valid_r  <= 1'b1;
						fwd_interrupt_number_r  <= 10'(FIRST_SPI) + 10'(sel_bus.sel_idx);
						fwd_prio_r   <= sel_bus.sel_prio;
						fwd_aff_r    <= route_aff_r[sel_bus.sel_idx];
						fwd_legacy_r <= !are_for({1'b1, sel_bus.sel_idx});
						fwd_any_r    <= route_irm_r[sel_bus.sel_idx] &&
							are_for({1'b1, sel_bus.sel_idx});
					end
				end
				FWD_OFFER: begin
					if (i_fwd_ack) begin
						state_r     <= FWD_SETTLE;
						fwd_valid_r <= 1'b0;
					end
				end
				// one spare cycle lets the owner drop pending, so no second delivery
				FWD_SETTLE: state_r <= FWD_IDLE;
				default: begin
					state_r     <= FWD_IDLE;
					fwd_valid_r <= 1'b0;
				end
			endcase
		end
	end

	assign o_ack          = ack_r;
	assign o_rdata        = rdata_r;
	assign o_fwd_valid    = fwd_valid_r;
	assign o_fwd_interrupt_number    = fwd_interrupt_number_r;
	assign o_fwd_prio     = fwd_prio_r;
	assign o_fwd_affinity = fwd_aff_r;
	assign o_fwd_any_pe   = fwd_any_r;
	assign o_fwd_legacy   = fwd_legacy_r;

	default clocking dclk @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	sequence offer_waiting_s;
		o_fwd_valid && !i_fwd_ack;
	endsequence
	sequence offer_held_s;
		o_fwd_valid && $stable(o_fwd_interrupt_number) && $stable(o_fwd_prio) && $stable(o_fwd_affinity);
	endsequence
	sequence offer_taken_s;
		o_fwd_valid && i_fwd_ack;
	endsequence

	offer_hold_a: assert property (offer_waiting_s |=> offer_held_s)
		else $error("offer changed before ack");
	offer_settle_a: assert property (offer_taken_s |=> !o_fwd_valid [*2])
		else $error("offer repeated right after ack");
	fwd_target_a: assert property (o_fwd_valid && !o_fwd_legacy && !o_fwd_any_pe
		|-> tgt_impl(o_fwd_affinity)) else $error("forwarded to absent element");
	lane_only_a: assert property (i_req && i_wr && prio_hit && !banked && i_size == SIZE_BYTE
		|=> (prio_shared_r[$past(prio_word[2:0])] & ~$past(byte_mask))
			== ($past(cur_word) & ~$past(byte_mask))) else $error("other lanes changed");
	prio_low_bits_a: assert property (i_req && !i_wr && prio_hit
		|=> (o_rdata[31:0] & ~{NUM_LANES{PRIO_IMPL_MASK}}) == 32'h0000_0000)
		else $error("unimplemented priority bits set");
	unimpl_raz_a: assert property (i_req && !i_wr && prio_hit && i_size == SIZE_BYTE
		&& !INT_IMPL_MASK[{prio_word, i_addr[1:0]}] |=> o_rdata == '0)
		else $error("absent interrupt field not zero");
	ns_secure_raz_a: assert property (i_req && !i_wr && prio_hit && i_size == SIZE_BYTE
		&& i_nonsecure && !i_security_disable && !i_int_ns_group[{prio_word, i_addr[1:0]}]
		|=> o_rdata == '0) else $error("secure priority leaked");
	bank_high_pe_a: assert property (i_req && !i_wr && prio_hit && banked && i_pe_num >= 8'(NUM_BANKS)
		|=> o_rdata == '0) else $error("high element saw a bank");
	banked_are_a: assert property (i_req && !i_wr && prio_hit && banked && i_size == SIZE_BYTE
		&& are_for({prio_word, i_addr[1:0]}) |=> o_rdata == '0)
		else $error("banked word visible under affinity");
	route_rsvd_a: assert property (i_req && !i_wr && route_hit && i_size == SIZE_DWORD
		|=> (o_rdata & ROUTE_RSVD) == '0) else $error("reserved routing bits set");
	route_off_a: assert property (i_req && !i_wr && route_hit && !are_for({1'b1, spi_idx})
		|=> o_rdata == '0) else $error("routing word visible without affinity");
endmodule

// ===== ipr_prio_select.sv
// Purpose: picks the most urgent pending shared interrupt
// Assumes: candidates are stable within a cycle
// Notes: lower value wins; ties go to the lower interrupt number
module ipr_prio_select import ipr_pkg::*; (
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	ipr_sel_if.pick   sel
);
	// linear scan; strict compare keeps the lowest number on a tie
	always_comb begin
		sel.found    = 1'b0;
		sel.sel_idx  = '0;
		sel.sel_prio = PRIO_IDLE;
		for (int k = 0; k < NUM_SPI; k++) begin
			if (sel.cand[k] && (!sel.found || sel.prio[k] < sel.sel_prio)) begin
				sel.found    = 1'b1;
				sel.sel_idx  = 5'(k);
				sel.sel_prio = sel.prio[k];
			end
		end
	end

	property pick_valid_p;
		@(posedge i_core_clk) disable iff (!i_rstn)
		sel.found |-> sel.cand[sel.sel_idx] && sel.prio[sel.sel_idx] == sel.sel_prio;
	endproperty
	pick_is_candidate_a: assert property (pick_valid_p) else $error("pick not a candidate");

	property none_means_empty_p;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!sel.found |-> sel.cand == '0;
	endproperty
	empty_pick_a: assert property (none_means_empty_p) else $error("candidate missed");
endmodule

// ===== ipr_sel_if.sv
// Purpose: carries shared-interrupt candidates to the urgency selector and its pick back
// Assumes: combinational path, sampled by the owner's clock
// Notes: prio entries are already masked to implemented bits
interface ipr_sel_if;
	import ipr_pkg::*;
	logic [NUM_SPI-1:0] cand;
	logic [7:0]         prio [NUM_SPI];
	logic               found;
	logic [4:0]         sel_idx;
	logic [7:0]         sel_prio;

	modport owner (output cand, output prio, input found, input sel_idx, input sel_prio);
	modport pick  (input cand, input prio, output found, output sel_idx, output sel_prio);
endinterface

// ===== test_irq_priority_affinity_routing.sv
// Purpose: self-checking bench for the priority and routing store
// Assumes: one request per cycle, ack one cycle later, reads answered in order
// Notes: expectations queue up at the driver; a negedge watcher pops and compares
module test_irq_priority_affinity_routing import ipr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [63:0] RMASK = {24'h0, AFF_IMPL_MASK[31:24], 8'h80, AFF_IMPL_MASK[23:0]};

	logic        i_core_clk         = 1'b0;
	logic        i_rstn             = 1'b0;
	logic        i_req              = 1'b0;
	logic        i_wr               = 1'b0;
	logic        i_nonsecure        = 1'b0;
	logic [1:0]  i_size             = 2'h0;
	logic [15:0] i_addr             = 16'h0000;
	logic [63:0] i_wdata            = 64'h0;
	logic [7:0]  i_pe_num           = 8'h00;
	logic        i_security_disable = 1'b0;
	logic        i_are_secure       = 1'b0;
	logic        i_are_nonsecure    = 1'b0;
	logic [63:0] i_int_ns_group     = '1;
	logic [63:0] i_nsacr_grant      = 64'h0;
	logic [31:0] i_spi_pending      = 32'h0;
	logic        i_fwd_ack          = 1'b0;
	logic        o_ack;
	logic [63:0] o_rdata;
	logic        o_fwd_valid;
	logic [9:0]  o_fwd_interrupt_number;
	logic [7:0]  o_fwd_prio;
	logic [31:0] o_fwd_affinity;
	logic        o_fwd_any_pe;
	logic        o_fwd_legacy;
	logic [63:0] rd_q[$];
	logic [51:0] fwd_q[$];
	logic        fwd_prev = 1'b0;
	int          errors = 0;
	int          check_count = 0;
	int          cyc = 0;

	ipr_prio_route u_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_req(i_req), .i_wr(i_wr),
		.i_nonsecure(i_nonsecure), .i_size(i_size), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_pe_num(i_pe_num), .o_ack(o_ack), .o_rdata(o_rdata),
		.i_security_disable(i_security_disable), .i_are_secure(i_are_secure),
		.i_are_nonsecure(i_are_nonsecure), .i_int_ns_group(i_int_ns_group),
		.i_nsacr_grant(i_nsacr_grant), .i_spi_pending(i_spi_pending), .i_fwd_ack(i_fwd_ack),
		.o_fwd_valid(o_fwd_valid), .o_fwd_interrupt_number(o_fwd_interrupt_number), .o_fwd_prio(o_fwd_prio),
		.o_fwd_affinity(o_fwd_affinity), .o_fwd_any_pe(o_fwd_any_pe), .o_fwd_legacy(o_fwd_legacy));

	// 4 ns clock
	initial begin
		forever #2 i_core_clk = ~i_core_clk;
	end

	task automatic fail(input string msg);
		$display("BAD %0t %s", $time, msg);
		errors++;
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cmp_rd(input logic [63:0] exp);
		check_count++;
		if (o_rdata !== exp) fail($sformatf("rdata %h want %h", o_rdata, exp));
	endtask

	task automatic cmp_fwd(input logic [51:0] exp);
		logic [51:0] got;
		got = {o_fwd_interrupt_number, o_fwd_prio, o_fwd_affinity, o_fwd_any_pe, o_fwd_legacy};
		check_count++;
		if (got !== exp) fail($sformatf("offer %h want %h", got, exp));
	endtask

	// request stays up across calls so back-to-back accesses need no idle gap
	task automatic acc(input logic wr, input logic ns, input logic [1:0] sz,
		input logic [15:0] a, input logic [63:0] wd, input logic [63:0] exp);
		i_req = 1'b1;
		i_wr = wr;
		i_nonsecure = ns;
		i_size = sz;
		i_addr = a;
		i_wdata = wd;
		rd_q.push_back(wr ? 64'h0 : exp);
		@(posedge i_core_clk);
		#1;
	endtask

	task automatic idle();
		i_req = 1'b0;
		@(posedge i_core_clk);
		#1;
	endtask

	task automatic wait_offer();
		int n;
		n = 0;
		while (o_fwd_valid !== 1'b1 && n < 50) begin
			@(posedge i_core_clk);
			#1;
			n++;
		end
		if (n == 50) fail("no offer");
	endtask

	task automatic take_offer(input int bit_k);
		i_fwd_ack = 1'b1;
		@(posedge i_core_clk);
		#1;
		i_fwd_ack = 1'b0;
		i_spi_pending[bit_k] = 1'b0;
	endtask

	// watcher: registered outputs are settled at the falling edge
	always @(negedge i_core_clk) begin
		if (o_ack === 1'b1) begin
			if (rd_q.size() == 0) fail("ack without request");
			else cmp_rd(rd_q.pop_front());
		end
		if (o_fwd_valid === 1'b1 && fwd_prev !== 1'b1) begin
			if (fwd_q.size() == 0) fail("unexpected offer");
			else cmp_fwd(fwd_q.pop_front());
		end
		fwd_prev = o_fwd_valid;
	end

	// hang guard, well above the hundred or so cycles the sequence needs
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		logic [31:0] w;
		logic [31:0] b1;
		logic [31:0] b2;
		logic [63:0] r;
		logic [63:0] e;
		void'($urandom(50));
		repeat (6) @(posedge i_core_clk);
		#1;
		i_rstn = 1'b1;
		acc(0, 0, SIZE_WORD, 16'h0400, 0, 0);
		acc(0, 0, SIZE_DWORD, 16'h6100, 0, 0);
		w = 32'h0;
		for (int l = 0; l < 4; l++) begin
			b1 = $urandom;
			w[l*8+:8] = b1[7:0] & PRIO_IMPL_MASK;
			acc(1, 1, SIZE_BYTE, 16'h0428 + 16'(l), {56'h0, b1[7:0]}, 0);
		end
		acc(0, 1, SIZE_BYTE, 16'h0429, 0, {56'h0, w[15:8]});
		acc(0, 1, SIZE_WORD, 16'h0428, 0, {32'h0, w});
		acc(1, 0, SIZE_BYTE, 16'h043F, 64'hF0, 0);
		acc(1, 0, SIZE_BYTE, 16'h043C, 64'h57, 0);
		acc(0, 0, SIZE_WORD, 16'h043C, 0, 64'h50);
		acc(0, 0, SIZE_WORD, 16'h0440, 0, 0);
		i_int_ns_group[44] = 1'b0;
		acc(1, 0, SIZE_BYTE, 16'h042C, 64'h30, 0);
		acc(1, 1, SIZE_BYTE, 16'h042C, 64'hC8, 0);
		acc(0, 1, SIZE_BYTE, 16'h042C, 0, 0);
		acc(0, 0, SIZE_BYTE, 16'h042C, 0, 64'h30);
		// with security disabled the secure-group field opens to non-secure reads
		i_security_disable = 1'b1;
		acc(0, 1, SIZE_BYTE, 16'h042C, 0, 64'h30);
		i_security_disable = 1'b0;
		b1 = $urandom;
		b2 = $urandom;
		i_pe_num = 8'd1;
		acc(1, 0, SIZE_WORD, 16'h0408, {32'h0, b1}, 0);
		i_pe_num = 8'd2;
		acc(1, 0, SIZE_WORD, 16'h0408, {32'h0, b2}, 0);
		acc(0, 0, SIZE_WORD, 16'h0408, 0, {32'h0, b2 & {4{PRIO_IMPL_MASK}}});
		i_pe_num = 8'd9;
		acc(1, 0, SIZE_WORD, 16'h0408, 64'hFFFF_FFFF, 0);
		acc(0, 0, SIZE_WORD, 16'h0408, 0, 0);
		i_pe_num = 8'd1;
		acc(0, 0, SIZE_WORD, 16'h0408, 0, {32'h0, b1 & {4{PRIO_IMPL_MASK}}});
		i_are_secure = 1'b1;
		i_are_nonsecure = 1'b1;
		idle();
		acc(0, 0, SIZE_WORD, 16'h0408, 0, 0);
		r = {$urandom, $urandom};
		r[31] = 1'b0;
		e = r & RMASK;
		acc(1, 0, SIZE_DWORD, 16'h6140, r, 0);
		acc(0, 0, SIZE_DWORD, 16'h6140, 0, e);
		acc(0, 0, SIZE_WORD, 16'h6144, 0, {32'h0, e[63:32]});
		acc(0, 0, SIZE_DWORD, 16'h6000, 0, 0);
		acc(1, 0, SIZE_DWORD, 16'h61F8, r, 0);
		acc(0, 0, SIZE_DWORD, 16'h61F8, 0, 0);
		r = {$urandom, $urandom};
		r[31] = 1'b1;
		e = r & RMASK;
		acc(1, 0, SIZE_DWORD, 16'h6140, r, 0);
		acc(1, 0, SIZE_DWORD, 16'h6140, ~r | 64'h8000_0000, 0);
		acc(0, 0, SIZE_DWORD, 16'h6140, 0, e);
		acc(1, 0, SIZE_DWORD, 16'h6140, 64'h0, 0);
		acc(0, 0, SIZE_DWORD, 16'h6140, 0, e & ~64'h8000_0000);
		i_int_ns_group[45] = 1'b0;
		acc(1, 1, SIZE_DWORD, 16'h6168, 64'h0000_0001_0000_0305, 0);
		acc(0, 0, SIZE_DWORD, 16'h6168, 0, 0);
		i_nsacr_grant[45] = 1'b1;
		acc(1, 1, SIZE_DWORD, 16'h6168, 64'h0000_0001_0000_0305, 0);
		acc(0, 1, SIZE_DWORD, 16'h6168, 0, 64'h0000_0001_0000_0305 & RMASK);
		acc(1, 0, SIZE_BYTE, 16'h0421, 64'h40, 0);
		acc(1, 0, SIZE_BYTE, 16'h0422, 64'h10, 0);
		acc(1, 0, SIZE_BYTE, 16'h0423, 64'h80, 0);
		acc(1, 0, SIZE_DWORD, 16'h6108, 64'h3, 0);
		acc(1, 0, SIZE_DWORD, 16'h6110, 64'h9, 0);
		acc(1, 0, SIZE_DWORD, 16'h6118, 64'h8000_0000, 0);
		idle();
		fwd_q.push_back({10'd33, 8'h40, 32'h3, 1'b0, 1'b0});
		fwd_q.push_back({10'd35, 8'h20, 32'h0, 1'b1, 1'b0});
		i_spi_pending = 32'h0000_000E;
		wait_offer();
		acc(1, 0, SIZE_BYTE, 16'h0423, 64'h20, 0);
		idle();
		take_offer(1);
		wait_offer();
		take_offer(3);
		repeat (20) idle();
		// affinity off for the stranded interrupt: legacy targets take over
		fwd_q.push_back({10'd34, 8'h10, 32'h9, 1'b0, 1'b1});
		i_are_nonsecure = 1'b0;
		wait_offer();
		take_offer(2);
		repeat (5) idle();
		if (rd_q.size() != 0 || fwd_q.size() != 0) fail("results missing");
		test_done();
	end
endmodule
